/* hw/pasc_top.sv */
// auto-shutdown and restart control with ahb-lite registers
//
// Notes on behaviour
// RL1: source codes 001, 010, 011 trip on comparator 1, 2, either.
// RL2: codes 100, 110, 111 trip on fault, fault or cmp2, all three.
// RL3: code 101 trips on fault or comparator 1.
// RL4: code 000 disables auto-shutdown; nothing trips.
// RL5: a/c pair in shutdown: 1x release, 01 high, 00 low.
// RL6: b/d pair in shutdown: 1x release, 01 high, 00 low.
// RL7: selected trip forces outputs at once and sets the event flag.
// RL8: fault input requests shutdown while low.
// RL9: auto restart enabled by bit 7 of dead-band delay register.
// RL10: with auto restart, flag clears by hardware when cause goes.
// RL11: without auto restart, flag stays set until firmware clears it.
// RL12: after flag clears, outputs stay forced until next period start.
// RL13: flag set at period start holds outputs forced whole period.
// RL14: writes to the flag are ignored while a trip is active.
// RL15: comparator trips are levels; flag cannot clear while asserted.
// RL16: writing 1 to the flag forces shutdown like a hardware event.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`include "pasc_consts.svh"

module pasc_top (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  input  pasc_pkg::pasc_trip_t    trip_in,
  input  wire logic               period_start,
  input  wire logic [3:0]         pwm_in,
  output pasc_pkg::pasc_pins_t    pwm_pins,
  output logic                    irq
);
  import pasc_pkg::*;

  pasc_state_t s_ff;
  pasc_state_t nxt_s;
  logic        trip_now;
  logic        forced;
  logic        wr_commit;
  logic        wr_ctl;
  logic [31:0] rd_word;
  logic [1:0]  irq_ev;

  // -------------------------------------------------------------
  // trip source decode
  // -------------------------------------------------------------
  // combinational so the pins follow a trip without a clock edge
  always_comb begin
    unique case (s_ff.ctl.shutdown_source_select)
      // RL4 no source selected
      `PASC_SRC_OFF:  trip_now = 1'b0;
      // RL1 RL15 comparator levels
      `PASC_SRC_C1:   trip_now = trip_in.cmp1;
      `PASC_SRC_C2:   trip_now = trip_in.cmp2;
      `PASC_SRC_C1C2: trip_now = trip_in.cmp1 | trip_in.cmp2;
      // RL2 RL8 fault low plus combinations
      `PASC_SRC_F:    trip_now = ~trip_in.fault_input_n;
      // RL3 fault or comparator 1
      `PASC_SRC_FC1:  trip_now = ~trip_in.fault_input_n | trip_in.cmp1;
      `PASC_SRC_FC2:  trip_now = ~trip_in.fault_input_n | trip_in.cmp2;
      `PASC_SRC_ALL:  trip_now = ~trip_in.fault_input_n | trip_in.cmp1
                                 | trip_in.cmp2;
    endcase
  end

  // RL7 RL12 RL13 forced while tripped, flagged or awaiting period
  assign forced = trip_now | s_ff.ctl.shutdown_event_flag
                  | (s_ff.run != PASC_RUN);

  pasc_pin_force u_force (
    .forced   (forced),
    .ac_state (s_ff.ctl.ac_pair_shutdown_state),
    .bd_state (s_ff.ctl.bd_pair_shutdown_state),
    .pwm_in   (pwm_in),
    .pins     (pwm_pins)
  );

  // -------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------
  // a frozen block stalls the bus rather than lose a transfer
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign wr_commit = ce & s_ff.dp_valid & s_ff.dp_write;
  assign wr_ctl    = wr_commit & (s_ff.dp_addr == `PASC_ADDR_CTL);

  always_comb begin
    rd_word = 32'h0;
    unique case (s_ff.dp_addr)
      `PASC_ADDR_CTL:     rd_word[7:0] = s_ff.ctl;
      `PASC_ADDR_DEL:     rd_word[7:0] = s_ff.del;
      `PASC_ADDR_IRQ_STS: rd_word[1:0] = s_ff.irq_sts;
      `PASC_ADDR_IRQ_MSK: rd_word[1:0] = s_ff.irq_msk;
      `PASC_ADDR_STAT:    rd_word[2:0] = {s_ff.run == PASC_RESUME,
                                          forced, trip_now};
      default:            rd_word = 32'h0;
    endcase
  end

  assign hrdata = (s_ff.dp_valid & ~s_ff.dp_write) ? rd_word : 32'h0;
  assign irq    = |(s_ff.irq_sts & s_ff.irq_msk);

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    irq_ev = 2'h0;

    // address phase capture, word accesses only
    nxt_s.dp_valid = hsel & hready & (htrans == `PASC_HTRANS_NSEQ)
                     & (hsize == `PASC_HSIZE_WORD);
    nxt_s.dp_write = hwrite;
    nxt_s.dp_addr  = haddr[7:0];

    // RL9 RL10 hardware clear once the cause is gone
    if (s_ff.del.auto_restart_enable & ~trip_now) begin
      nxt_s.ctl.shutdown_event_flag = 1'b0;
    end

    if (wr_ctl) begin
      nxt_s.ctl.shutdown_source_select = hwdata[6:4];
      nxt_s.ctl.ac_pair_shutdown_state = hwdata[3:2];
      nxt_s.ctl.bd_pair_shutdown_state = hwdata[1:0];
      // RL14 RL16 RL11 flag written only when no trip stands
      if (~trip_now) begin
        nxt_s.ctl.shutdown_event_flag = hwdata[`PASC_CTL_FLAG_BIT];
      end
    end

    // RL7 RL15 a trip sets the flag and wins over any clear
    if (trip_now) begin
      nxt_s.ctl.shutdown_event_flag = 1'b1;
    end

    if (wr_commit & (s_ff.dp_addr == `PASC_ADDR_DEL)) begin
      nxt_s.del = hwdata[7:0];
    end
    if (wr_commit & (s_ff.dp_addr == `PASC_ADDR_IRQ_MSK)) begin
      nxt_s.irq_msk = hwdata[1:0];
    end

    // RL12 RL13 release only on a period boundary
    unique case (s_ff.run)
      PASC_RUN: begin
        if (s_ff.ctl.shutdown_event_flag | trip_now) begin
          nxt_s.run = PASC_SHUT;
        end
      end
      PASC_SHUT: begin
        if (~s_ff.ctl.shutdown_event_flag & ~trip_now) begin
          nxt_s.run = PASC_RESUME;
        end
      end
      PASC_RESUME: begin
        if (s_ff.ctl.shutdown_event_flag | trip_now) begin
          nxt_s.run = PASC_SHUT;
        end else if (period_start) begin
          nxt_s.run = PASC_RUN;
          irq_ev[`PASC_IRQ_RES_BIT] = 1'b1;
        end
      end
    endcase

    irq_ev[`PASC_IRQ_SHUT_BIT] = ~s_ff.ctl.shutdown_event_flag
                                 & nxt_s.ctl.shutdown_event_flag;

    // write-one-to-clear; a same-cycle event wins
    if (wr_commit & (s_ff.dp_addr == `PASC_ADDR_IRQ_STS)) begin
      nxt_s.irq_sts = s_ff.irq_sts & ~hwdata[1:0];
    end
    nxt_s.irq_sts = nxt_s.irq_sts | irq_ev;
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [2:0] src;
  assign src = s_ff.ctl.shutdown_source_select;

  property p_src_off;
    (src == `PASC_SRC_OFF) |-> !trip_now;
  endproperty
  a_src_off: assert property (p_src_off) // RL4
    else $error("trip with no source selected");

  property p_src_cmp;
    (src == `PASC_SRC_C1 && trip_in.cmp1 && !trip_in.cmp2)
      |-> trip_now;
  endproperty
  a_src_cmp: assert property (p_src_cmp) // RL1
    else $error("comparator 1 did not trip");

  property p_src_fault;
    (src == `PASC_SRC_F) |-> (trip_now == !trip_in.fault_input_n);
  endproperty
  a_src_fault: assert property (p_src_fault) // RL2
    else $error("fault source decode wrong");

  property p_src_fc1;
    (src == `PASC_SRC_FC1)
      |-> (trip_now == (!trip_in.fault_input_n || trip_in.cmp1));
  endproperty
  a_src_fc1: assert property (p_src_fc1) // RL3
    else $error("fault or comparator 1 decode wrong");

  property p_trip_now;
    trip_now |-> forced ##1 (!$past(ce) || s_ff.ctl.shutdown_event_flag);
  endproperty
  a_trip_now: assert property (p_trip_now) // RL7
    else $error("trip did not force and set flag");

  property p_ac_release;
    (forced && s_ff.ctl.ac_pair_shutdown_state[1])
      |-> (pwm_pins.oe[0] == 1'b0 && pwm_pins.oe[2] == 1'b0);
  endproperty
  a_ac_release: assert property (p_ac_release) // RL5
    else $error("a/c pair not released");

  property p_bd_high;
    (forced && s_ff.ctl.bd_pair_shutdown_state == 2'h1)
      |-> (pwm_pins.oe[1] && pwm_pins.oe[3]
           && pwm_pins.level[1] && pwm_pins.level[3]);
  endproperty
  a_bd_high: assert property (p_bd_high) // RL6
    else $error("b/d pair not driven high");

  property p_auto_clear;
    (ce && s_ff.del.auto_restart_enable && !trip_now && !wr_ctl
     && s_ff.ctl.shutdown_event_flag) |=> !s_ff.ctl.shutdown_event_flag;
  endproperty
  a_auto_clear: assert property (p_auto_clear) // RL10
    else $error("flag not cleared by auto restart");

  property p_hold_flag;
    (ce && !s_ff.del.auto_restart_enable && !wr_ctl
     && s_ff.ctl.shutdown_event_flag) |=> s_ff.ctl.shutdown_event_flag;
  endproperty
  a_hold_flag: assert property (p_hold_flag) // RL11
    else $error("flag dropped without firmware");

  sequence s_flag_drop;
    $fell(s_ff.ctl.shutdown_event_flag) && !trip_now;
  endsequence
  sequence s_wait_period;
    forced [*2];
  endsequence
  property p_resume_wait;
    (s_flag_drop and (!period_start [*2])) |-> s_wait_period;
  endproperty
  a_resume_wait: assert property (p_resume_wait) // RL12
    else $error("outputs released before period start");

  property p_period_hold;
    (ce && period_start && s_ff.ctl.shutdown_event_flag) |=> forced;
  endproperty
  a_period_hold: assert property (p_period_hold) // RL13
    else $error("period began unforced with flag set");

  property p_wr_ignored;
    (wr_ctl && trip_now && !hwdata[7]) |=> s_ff.ctl.shutdown_event_flag;
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) // RL14
    else $error("flag cleared during active trip");

  property p_cmp_level;
    (ce && src == `PASC_SRC_C2 && trip_in.cmp2)
      |=> s_ff.ctl.shutdown_event_flag;
  endproperty
  a_cmp_level: assert property (p_cmp_level) // RL15
    else $error("flag clear while comparator asserts");

  property p_sw_force;
    (wr_ctl && hwdata[7]) |=> (s_ff.ctl.shutdown_event_flag && forced);
  endproperty
  a_sw_force: assert property (p_sw_force) // RL16
    else $error("software force did not shut down");

  property p_src_c2;
    (src == `PASC_SRC_C2) |-> (trip_now == trip_in.cmp2);
  endproperty
  a_src_c2: assert property (p_src_c2) // RL1
    else $error("comparator 2 decode wrong");

  property p_src_fc2;
    (src == `PASC_SRC_FC2)
      |-> (trip_now == (!trip_in.fault_input_n || trip_in.cmp2));
  endproperty
  a_src_fc2: assert property (p_src_fc2) // RL2
    else $error("fault or comparator 2 decode wrong");

  property p_ac_drive;
    (forced && !s_ff.ctl.ac_pair_shutdown_state[1])
      |-> (pwm_pins.oe[0] && pwm_pins.oe[2]
           && pwm_pins.level[0] == s_ff.ctl.ac_pair_shutdown_state[0]
           && pwm_pins.level[2] == s_ff.ctl.ac_pair_shutdown_state[0]);
  endproperty
  a_ac_drive: assert property (p_ac_drive) // RL5
    else $error("a/c pair not driven to its state");

  property p_bd_release;
    (forced && s_ff.ctl.bd_pair_shutdown_state[1])
      |-> (pwm_pins.oe[1] == 1'b0 && pwm_pins.oe[3] == 1'b0);
  endproperty
  a_bd_release: assert property (p_bd_release) // RL6
    else $error("b/d pair not released");

  property p_unforced;
    !forced |-> (pwm_pins.oe == 4'hf && pwm_pins.level == pwm_in);
  endproperty
  a_unforced: assert property (p_unforced) // RL12
    else $error("pins not following pwm while running");

  // resume step: waiting state meets a clean period boundary
  sequence s_resume_edge;
    ce && s_ff.run == PASC_RESUME && period_start && !trip_now
    && !s_ff.ctl.shutdown_event_flag;
  endsequence
  property p_resume_edge;
    s_resume_edge |=> (s_ff.run == PASC_RUN && s_ff.irq_sts[1]);
  endproperty
  a_resume_edge: assert property (p_resume_edge) // RL12
    else $error("no resume at period start");

  property p_flag_irq;
    $rose(s_ff.ctl.shutdown_event_flag) |-> s_ff.irq_sts[0];
  endproperty
  a_flag_irq: assert property (p_flag_irq) // RL7
    else $error("shutdown event not recorded");

endmodule

/* hw/pasc_consts.svh */
// register offsets, field positions, codes and reset values
`ifndef PASC_CONSTS_SVH
`define PASC_CONSTS_SVH

// ---------------------------------------------------------------
// register byte addresses (low 8 address bits decoded)
// ---------------------------------------------------------------
`define PASC_ADDR_CTL     8'h00
`define PASC_ADDR_DEL     8'h04
`define PASC_ADDR_IRQ_STS 8'h08
`define PASC_ADDR_IRQ_MSK 8'h0c
`define PASC_ADDR_STAT    8'h10

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define PASC_CTL_FLAG_BIT 7
`define PASC_DEL_RSEN_BIT 7
`define PASC_CTL_RST      8'h00
`define PASC_DEL_RST      8'h00
`define PASC_IRQ_RST      2'h0
`define PASC_IRQ_SHUT_BIT 0
`define PASC_IRQ_RES_BIT  1

// ---------------------------------------------------------------
// shutdown source select codes
// ---------------------------------------------------------------
`define PASC_SRC_OFF      3'h0
`define PASC_SRC_C1       3'h1
`define PASC_SRC_C2       3'h2
`define PASC_SRC_C1C2     3'h3
`define PASC_SRC_F        3'h4
`define PASC_SRC_FC1      3'h5
`define PASC_SRC_FC2      3'h6
`define PASC_SRC_ALL      3'h7

// ---------------------------------------------------------------
// bus constants
// ---------------------------------------------------------------
`define PASC_HTRANS_NSEQ  2'h2
`define PASC_HSIZE_WORD   3'h2

`endif

/* hw/pasc_pkg.sv */
// types shared by the auto-shutdown control block
package pasc_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic       shutdown_event_flag;
    logic [2:0] shutdown_source_select;
    logic [1:0] ac_pair_shutdown_state;
    logic [1:0] bd_pair_shutdown_state;
  } pasc_ctl_t;

  typedef struct packed {
    logic       auto_restart_enable;
    logic [6:0] delay_count;
  } pasc_del_t;

  // trip sources as they arrive
  typedef struct packed {
    logic cmp1;
    logic cmp2;
    logic fault_input_n;
  } pasc_trip_t;

  // pins, bit 0 = A, 1 = B, 2 = C, 3 = D
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pasc_pins_t;

  typedef enum logic [1:0] {
    PASC_RUN,
    PASC_SHUT,
    PASC_RESUME
  } pasc_run_t;

  typedef struct packed {
    pasc_ctl_t  ctl;
    pasc_del_t  del;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    pasc_run_t  run;
    logic       dp_valid;
    logic       dp_write;
    logic [7:0] dp_addr;
  } pasc_state_t;

endpackage

/* hw/pasc_pin_force.sv */
// per-pin override of the pwm outputs by the shutdown states
module pasc_pin_force (
  input  wire logic               forced,
  input  wire logic [1:0]         ac_state,
  input  wire logic [1:0]         bd_state,
  input  wire logic [3:0]         pwm_in,
  output pasc_pkg::pasc_pins_t    pins
);
  import pasc_pkg::*;

  // -------------------------------------------------------------
  // pin loop: even pins are the a/c pair, odd pins b/d
  // -------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_pin
    logic [1:0] sel;
    assign sel = (i % 2 == 0) ? ac_state : bd_state;
    // RL5 RL6 pair states
    // upper bit set releases the pin, else drive lower bit
    assign pins.oe[i]    = forced ? ~sel[1] : 1'b1;
    assign pins.level[i] = forced ? (~sel[1] & sel[0]) : pwm_in[i];
  end

endmodule

/* verification/pasc_bridge_model.sv */
// bridge switches and trip sources seen from the pwm output stage
module pasc_bridge_model (
  input  wire logic [2:0]      trip_req,
  input  pasc_pkg::pasc_pins_t pins,
  output pasc_pkg::pasc_trip_t trip,
  output logic [3:0]           gate
);
  timeunit 1ns;
  timeprecision 1ps;
  import pasc_pkg::*;
  // ---------------------------------------------------------------
  // trip sources: bit0 cmp1, bit1 cmp2, bit2 fault
  // ---------------------------------------------------------------
  // fault active low
  assign trip.fault_input_n = ~trip_req[2];
  assign trip.cmp2          = trip_req[1];
  assign trip.cmp1          = trip_req[0];
  // ---------------------------------------------------------------
  // gate drive
  // ---------------------------------------------------------------
  // released pin: pull-down keeps the switch off
  assign gate = pins.level & pins.oe;
endmodule

/* verification/pwm_auto_shutdown_control_tb.sv */
// self-checking bench of the auto-shutdown control block
`include "pasc_consts.svh"

module pwm_auto_shutdown_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pasc_pkg::*;
  logic        hclk;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        period_start = 1'b0;
  logic        ce = 1'b1;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = `PASC_HSIZE_WORD;
  logic [2:0]  trip_req = 3'h0;
  logic [3:0]  pwm_in = 4'h0;
  logic [3:0]  gate;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic [1:0]  ac;
  logic [1:0]  bd;
  logic        h;
  pasc_trip_t  trip;
  pasc_pins_t  pins;
  int          n_fail = 0;
  int          num_checks = 0;

  pasc_top u_pasc_top (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .trip_in(trip), .period_start(period_start), .pwm_in(pwm_in),
    .pwm_pins(pins), .irq(irq));

  pasc_bridge_model u_pasc_bridge_model (.trip_req(trip_req),
    .pins(pins), .trip(trip), .gate(gate));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------
  // code bits line up with trip_req bits
  function automatic logic hit(input logic [2:0] c, input logic [2:0] s);
    return |(c & s);
  endfunction

  // {gate, oe}: tri-stated pins read low through the pull-down
  function automatic logic [7:0] exp_pins(input logic f,
      input logic [1:0] a, input logic [1:0] b, input logic [3:0] p);
    logic [1:0] st;
    logic [7:0] e;
    e = {p, 4'hf};
    for (int i = 0; i < 4; i++) begin
      st = i[0] ? b : a;
      if (f) begin
        e[i+4] = ~st[1] & st[0];
        e[i]   = ~st[1];
      end
    end
    return e;
  endfunction

  // ---------------------------------------------------------------
  // stimulus helpers
  // ---------------------------------------------------------------
  // zero wait states expected, but the master never assumes it
  task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= `PASC_HTRANS_NSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk(hresp, 0);
  endtask

  task automatic pulse;
    @(posedge hclk);
    period_start <= 1'b1;
    @(posedge hclk);
    period_start <= 1'b0;
  endtask

  task automatic pins_is(input logic f);
    #1;
    chk({gate, pins.oe}, exp_pins(f, ac, bd, pwm_in));
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hfe7db8f1));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, `PASC_ADDR_CTL, 0);
    chk(rd, `PASC_CTL_RST);
    ahb(0, `PASC_ADDR_DEL, 0);
    chk(rd, `PASC_DEL_RST);
    ahb(0, 8'h20, 0);
    chk(rd, 0);
    ahb(1, `PASC_ADDR_IRQ_MSK, 3);
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 3; s++) begin
        ac = 2'($urandom);
        bd = 2'($urandom);
        ahb(1, `PASC_ADDR_CTL, {25'h0, c[2:0], ac, bd});
        h = hit(c[2:0], 3'h1 << s);
        @(posedge hclk);
        trip_req <= 3'h1 << s;
        pwm_in   <= 4'($urandom);
        pins_is(h);
        ahb(0, `PASC_ADDR_IRQ_STS, 0);
        chk(irq, h);
        chk(rd, {31'h0, h});
        trip_req <= 3'h0;
        pulse();
        pins_is(h);
        ahb(0, `PASC_ADDR_CTL, 0);
        chk(rd[7], h);
        ahb(1, `PASC_ADDR_CTL, {25'h0, c[2:0], ac, bd});
        pins_is(h);
        pulse();
        pins_is(1'b0);
        ahb(0, `PASC_ADDR_IRQ_STS, 0);
        chk(rd, {30'h0, h, h});
        ahb(1, `PASC_ADDR_IRQ_STS, 3);
        #1 chk(irq, 0);
      end
    end
    // flag writes while comparator 1 still trips
    ac = 2'h3;
    bd = 2'h3;
    ahb(1, `PASC_ADDR_CTL, 8'h1f);
    @(posedge hclk);
    trip_req <= 3'h1;
    ahb(1, `PASC_ADDR_CTL, 8'h1f);
    ahb(0, `PASC_ADDR_CTL, 0);
    chk(rd[7], 1);
    ahb(1, `PASC_ADDR_DEL, 8'h80);
    ahb(0, `PASC_ADDR_DEL, 0);
    chk(rd, 8'h80);
    ahb(0, `PASC_ADDR_CTL, 0);
    chk(rd[7], 1);
    trip_req <= 3'h0;
    repeat (3) @(posedge hclk);
    ahb(0, `PASC_ADDR_CTL, 0);
    chk(rd[7], 0);
    pins_is(1'b1);
    pulse();
    pins_is(1'b0);
    // software-forced shutdown
    ac = 2'h0;
    bd = 2'h1;
    ahb(1, `PASC_ADDR_DEL, 0);
    ahb(1, `PASC_ADDR_CTL, 8'h81);
    pins_is(1'b1);
    ahb(0, `PASC_ADDR_CTL, 0);
    chk(rd[7], 1);
    ahb(1, `PASC_ADDR_CTL, 8'h01);
    ahb(0, `PASC_ADDR_STAT, 0);
    chk(rd, 32'h6);
    pulse();
    pins_is(1'b0);
    // frozen block: pins still follow a trip, the flag does not
    ahb(1, `PASC_ADDR_CTL, 8'h11);
    ce       <= 1'b0;
    trip_req <= 3'h1;
    pins_is(1'b1);
    repeat (3) @(posedge hclk);
    trip_req <= 3'h0;
    @(posedge hclk);
    ce <= 1'b1;
    ahb(0, `PASC_ADDR_CTL, 0);
    chk(rd, 32'h11);
    // byte-sized write must leave the register alone
    hsize <= 3'h0;
    ahb(1, `PASC_ADDR_CTL, 8'h70);
    hsize <= `PASC_HSIZE_WORD;
    ahb(0, `PASC_ADDR_CTL, 0);
    chk(rd, 32'h11);
    give_verdict();
  end

  // run needs about 640 cycles
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
